// >>> rtl/mcuao_core.sv
// Execution datapath with Avalon-MM register access
// Operation
// - Power-down flag is 1 after power-up and after each watchdog clear.
// - Power-down flag goes to 0 when halt entry executes.
// - Timeout flag is 1 after power-up, watchdog clear or halt entry; here a timeout in the same cycle wins and leaves it 0.
// - Timeout flag goes to 0 when the watchdog counter times out.
// - Register operands address the primary page 0 to 0x7f.
// - The secondary page spans addresses 0 to 0x1f.
// - For register adds and AND, selector 0 writes the result to the accumulator, 1 to the register; immediate adds always write the accumulator.
// - Add register with carry sums accumulator, register and carry in one cycle.
// - Plain adds sum accumulator and operand without carry in one cycle.
// - Add immediate with carry adds accumulator, immediate and carry.
// - AND with register touches only the zero flag, in one cycle.
// - Bit clear zeroes bit 0 to 7 of the register, flags untouched.
// - Immediates are unsigned 8-bit values 0 to 255.
// - Carry reads 1 on a carry out of an addition, else 0.
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
module mcuao_core (
	// Clock and reset
	input wire logic i_clock,
	input wire logic i_arst_n,
	// Avalon-MM slave
	input wire logic [mcuao_pkg::ADDR_W-1:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [mcuao_pkg::DATA_W-1:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [mcuao_pkg::DATA_W-1:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Watchdog event, same clock
	input wire logic i_watchdog_timeout,
	// Status flags
	output logic o_power_down_flag,
	output logic o_timeout_flag
);
	logic wait_q;
	logic wait_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [7:0] accum_q;
	logic [7:0] accum_d;
	logic z_q;
	logic z_d;
	logic dcarry_q;
	logic dcarry_d;
	logic c_q;
	logic c_d;
	logic pwrdn_q;
	logic pwrdn_d;
	logic to_q;
	logic to_d;
	logic [7:0] rpage_q [mcuao_pkg::RPAGE_DEPTH];
	logic [7:0] spage_q [mcuao_pkg::SPAGE_DEPTH];
	logic r_we;
	logic [6:0] r_wa;
	logic [7:0] r_wd;
	logic s_we;
	logic [4:0] s_wa;
	logic [7:0] s_wd;
	logic done;
	logic issue;
	logic rhit;
	logic shit;
	logic [6:0] r_idx;
	logic [4:0] s_idx;
	logic [11:0] r_off;
	logic [11:0] s_off;
	mcuao_pkg::mcuao_op_t op;
	logic [6:0] ra;
	logic dest;
	logic [2:0] bsel;
	logic [7:0] imm;
	logic [7:0] opnd;
	logic [7:0] addend;
	logic cin;
	logic [8:0] sum9;
	logic [4:0] lo5;
	logic [7:0] res;

	// Operand fields of an instruction word
	assign op = mcuao_pkg::mcuao_op_t'(i_avs_writedata[mcuao_pkg::OP_LSB +:
		mcuao_pkg::OP_W]);
	assign ra = i_avs_writedata[mcuao_pkg::RA_LSB +: mcuao_pkg::RA_W];
	assign dest = i_avs_writedata[mcuao_pkg::DEST_POS];
	assign bsel = i_avs_writedata[mcuao_pkg::BIT_LSB +: mcuao_pkg::BIT_W];
	assign imm = i_avs_writedata[mcuao_pkg::IMM_LSB +: mcuao_pkg::IMM_W];
	assign opnd = rpage_q[ra];
	// Page windows: one word per byte register
	assign r_off = i_avs_address - mcuao_pkg::OFS_RPAGE;
	assign s_off = i_avs_address - mcuao_pkg::OFS_SPAGE;
	assign r_idx = r_off[8:2];
	assign s_idx = s_off[6:2];
	assign rhit = (i_avs_address >= mcuao_pkg::OFS_RPAGE) &&
		(i_avs_address[1:0] == 2'h0) &&
		(r_off[11:2] <= {3'h0, mcuao_pkg::RPAGE_LAST});
	assign shit = (i_avs_address >= mcuao_pkg::OFS_SPAGE) &&
		(i_avs_address[1:0] == 2'h0) &&
		(s_off[11:2] <= {5'h00, mcuao_pkg::SPAGE_LAST});
	// Write completes only at the edge where waitrequest is seen low
	assign done = i_avs_write && !wait_q;
	assign issue = done && (i_avs_address == mcuao_pkg::OFS_INSTR) &&
		(i_avs_byteenable[2:0] == 3'h7);

	// Adder operand selection
	always_comb
	begin
		addend = opnd;
		cin = 1'b0;
		case (op)
			mcuao_pkg::OP_ADD_REG_WITH_CARRY: cin = c_q;
			mcuao_pkg::OP_ADD_IMM_WITH_CARRY:
			begin
				addend = imm;
				cin = c_q;
			end
			mcuao_pkg::OP_ADD_IMM: addend = imm;
			default: cin = 1'b0;
		endcase
		sum9 = {1'b0, accum_q} + {1'b0, addend} + {8'h00, cin};
		lo5 = {1'b0, accum_q[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
		res = (op == mcuao_pkg::OP_AND_WITH_REG) ? (accum_q & opnd) :
			sum9[7:0];
	end

	// Bus answer, instruction execution and flags
	always_comb
	begin
		wait_d = 1'b1;
		rdata_d = rdata_q;
		accum_d = accum_q;
		z_d = z_q;
		dcarry_d = dcarry_q;
		c_d = c_q;
		pwrdn_d = pwrdn_q;
		to_d = to_q;
		r_we = 1'b0;
		r_wa = ra;
		r_wd = res;
		s_we = 1'b0;
		s_wa = s_idx;
		s_wd = i_avs_writedata[7:0];
		// One wait cycle, then a single cycle with waitrequest low
		if ((i_avs_read || i_avs_write) && wait_q)
		begin
			wait_d = 1'b0;
			rdata_d = 32'h0000_0000;
			if (i_avs_address == mcuao_pkg::OFS_ACCUM)
				rdata_d[7:0] = accum_q;
			else if (i_avs_address == mcuao_pkg::OFS_STATUS)
			begin
				rdata_d[mcuao_pkg::ST_Z] = z_q;
				rdata_d[mcuao_pkg::ST_DCARRY] = dcarry_q;
				rdata_d[mcuao_pkg::ST_C] = c_q;
				rdata_d[mcuao_pkg::ST_PWRDN] = pwrdn_q;
				rdata_d[mcuao_pkg::ST_TO] = to_q;
			end
			else if (rhit)
				rdata_d[7:0] = rpage_q[r_idx];
			else if (shit)
				rdata_d[7:0] = spage_q[s_idx];
		end
		if (done && i_avs_byteenable[0])
		begin
			if (i_avs_address == mcuao_pkg::OFS_ACCUM)
				accum_d = i_avs_writedata[7:0];
			else if (i_avs_address == mcuao_pkg::OFS_STATUS)
			begin
				// Power-down and timeout flags are read-only
				z_d = i_avs_writedata[mcuao_pkg::ST_Z];
				dcarry_d = i_avs_writedata[mcuao_pkg::ST_DCARRY];
				c_d = i_avs_writedata[mcuao_pkg::ST_C];
			end
			else if (rhit)
			begin
				r_we = 1'b1;
				r_wa = r_idx;
				r_wd = i_avs_writedata[7:0];
			end
			else if (shit)
				s_we = 1'b1;
		end
		if (issue)
		begin
			case (op)
				mcuao_pkg::OP_ADD_REG_WITH_CARRY, mcuao_pkg::OP_ADD_REG,
				mcuao_pkg::OP_ADD_IMM_WITH_CARRY, mcuao_pkg::OP_ADD_IMM:
				begin
					z_d = (sum9[7:0] == 8'h00);
					dcarry_d = lo5[4];
					c_d = sum9[8];
					if (dest == mcuao_pkg::DEST_REG &&
						(op == mcuao_pkg::OP_ADD_REG_WITH_CARRY ||
						op == mcuao_pkg::OP_ADD_REG))
						r_we = 1'b1;
					else
						accum_d = sum9[7:0];
				end
				mcuao_pkg::OP_AND_WITH_REG:
				begin
					z_d = (res == 8'h00);
					if (dest == mcuao_pkg::DEST_REG)
						r_we = 1'b1;
					else
						accum_d = res;
				end
				mcuao_pkg::OP_BIT_CLEAR:
				begin
					r_we = 1'b1;
					r_wd = opnd & ~(8'h01 << bsel);
				end
				mcuao_pkg::OP_WATCHDOG_CLEAR:
				begin
					pwrdn_d = 1'b1;
					to_d = 1'b1;
				end
				mcuao_pkg::OP_HALT_ENTRY:
				begin
					pwrdn_d = 1'b0;
					to_d = 1'b1;
				end
				default: pwrdn_d = pwrdn_q;
			endcase
		end
		// A timeout is an event and must not be lost to a same-cycle set
		if (i_watchdog_timeout)
			to_d = 1'b0;
	end

	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			accum_q <= mcuao_pkg::ACCUM_RST;
			z_q <= mcuao_pkg::FLAG_RST;
			dcarry_q <= mcuao_pkg::FLAG_RST;
			c_q <= mcuao_pkg::FLAG_RST;
			pwrdn_q <= mcuao_pkg::PWRDN_RST;
			to_q <= mcuao_pkg::TO_RST;
		end
		else
		begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			accum_q <= accum_d;
			z_q <= z_d;
			dcarry_q <= dcarry_d;
			c_q <= c_d;
			pwrdn_q <= pwrdn_d;
			to_q <= to_d;
		end
	end

	// Register pages; reset so reads never return unknowns
	always_ff @(posedge i_clock or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			for (int k = 0; k < mcuao_pkg::RPAGE_DEPTH; k++)
				rpage_q[k] <= 8'h00;
			for (int k = 0; k < mcuao_pkg::SPAGE_DEPTH; k++)
				spage_q[k] <= 8'h00;
		end
		else
		begin
			if (r_we)
				rpage_q[r_wa] <= r_wd;
			if (s_we)
				spage_q[s_wa] <= s_wd;
		end
	end

	assign o_avs_waitrequest = wait_q;
	assign o_avs_readdata = rdata_q;
	assign o_power_down_flag = pwrdn_q;
	assign o_timeout_flag = to_q;

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_arst_n);

	sequence s_op(logic [3:0] code);
		issue && op == code;
	endsequence
	sequence s_quiet;
		!i_watchdog_timeout;
	endsequence

	pwrdn_set_a: assert property (
		s_op(mcuao_pkg::OP_WATCHDOG_CLEAR) |=> pwrdn_q)
		else $error("power-down flag not set by watchdog clear");
	pwrdn_clear_a: assert property (
		s_op(mcuao_pkg::OP_HALT_ENTRY) |=> !pwrdn_q)
		else $error("power-down flag not cleared by halt");
	to_set_a: assert property (
		(s_op(mcuao_pkg::OP_WATCHDOG_CLEAR) or
		s_op(mcuao_pkg::OP_HALT_ENTRY)) and s_quiet |=> to_q)
		else $error("timeout flag not set");
	to_clear_a: assert property (i_watchdog_timeout |=> !to_q)
		else $error("timeout flag not cleared on timeout");
	dest_accum_a: assert property (
		s_op(mcuao_pkg::OP_ADD_REG) ##0 dest == mcuao_pkg::DEST_ACCUM |=>
		accum_q == $past(accum_q) + $past(opnd))
		else $error("add result not in accumulator");
	adc_sum_a: assert property (
		s_op(mcuao_pkg::OP_ADD_REG_WITH_CARRY) |=>
		c_q == $past(({1'b0, accum_q} + {1'b0, opnd} +
		{8'h00, c_q}) > 9'h0ff))
		else $error("add with carry wrong carry");
	add_nocarry_a: assert property (
		s_op(mcuao_pkg::OP_ADD_IMM) |=>
		accum_q == $past(accum_q + imm) && z_q == (accum_q == 8'h00))
		else $error("plain immediate add wrong");
	adci_sum_a: assert property (
		s_op(mcuao_pkg::OP_ADD_IMM_WITH_CARRY) |=>
		accum_q == $past(accum_q + imm + {7'h00, c_q}))
		else $error("immediate add with carry wrong");
	and_flags_a: assert property (
		s_op(mcuao_pkg::OP_AND_WITH_REG) |=> $stable(c_q) &&
		$stable(dcarry_q) && z_q == ($past(accum_q & opnd) == 8'h00))
		else $error("AND touched carry flags");
	bclr_flags_a: assert property (
		s_op(mcuao_pkg::OP_BIT_CLEAR) |=> $stable({z_q, dcarry_q, c_q}) &&
		rpage_q[$past(ra)][$past(bsel)] == 1'b0)
		else $error("bit clear wrong");
	dcarry_nibble_a: assert property (
		s_op(mcuao_pkg::OP_ADD_REG) |=>
		dcarry_q == $past(({1'b0, accum_q[3:0]} +
		{1'b0, opnd[3:0]}) > 5'h0f))
		else $error("digital carry wrong");
	wait_pulse_a: assert property ((i_avs_read || i_avs_write) && wait_q |=>
		!o_avs_waitrequest ##1 o_avs_waitrequest)
		else $error("waitrequest not a single low cycle");
endmodule : mcuao_core

// >>> rtl/mcuao_pkg.sv
// Shared constants for the arithmetic and logic execution block
package mcuao_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// Byte offsets on the register bus
	localparam logic [11:0] OFS_INSTR = 12'h000;
	localparam logic [11:0] OFS_ACCUM = 12'h004;
	localparam logic [11:0] OFS_STATUS = 12'h008;
	localparam logic [11:0] OFS_RPAGE = 12'h200;
	localparam logic [11:0] OFS_SPAGE = 12'h400;
	// Operand address ranges
	localparam logic [6:0] RPAGE_LAST = 7'h7f;
	localparam logic [4:0] SPAGE_LAST = 5'h1f;
	localparam int RPAGE_DEPTH = 128;
	localparam int SPAGE_DEPTH = 32;
	// Instruction word fields
	localparam int OP_LSB = 0;
	localparam int OP_W = 4;
	localparam int RA_LSB = 4;
	localparam int RA_W = 7;
	localparam int DEST_POS = 11;
	localparam int BIT_LSB = 12;
	localparam int BIT_W = 3;
	localparam int IMM_LSB = 16;
	localparam int IMM_W = 8;
	// Destination selector values
	localparam logic DEST_ACCUM = 1'b0;
	localparam logic DEST_REG = 1'b1;
	// Status word bit positions
	localparam int ST_Z = 0;
	localparam int ST_DCARRY = 1;
	localparam int ST_C = 2;
	localparam int ST_PWRDN = 3;
	localparam int ST_TO = 4;
	// Reset values
	localparam logic [7:0] ACCUM_RST = 8'h00;
	localparam logic PWRDN_RST = 1'b1;
	localparam logic TO_RST = 1'b1;
	localparam logic FLAG_RST = 1'b0;
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_ADD_REG_WITH_CARRY = 4'h1,
		OP_ADD_REG = 4'h2,
		OP_ADD_IMM_WITH_CARRY = 4'h3,
		OP_ADD_IMM = 4'h4,
		OP_AND_WITH_REG = 4'h5,
		OP_BIT_CLEAR = 4'h6,
		OP_WATCHDOG_CLEAR = 4'h7,
		OP_HALT_ENTRY = 4'h8
	} mcuao_op_t;
endpackage : mcuao_pkg

// >>> verif/mcu_arith_logic_ops_tb.sv
// Self-checking bench for the arithmetic and logic execution block
`timescale 1ns/1ps
module mcu_arith_logic_ops_tb;
	localparam int LIMIT = 5000;
	logic i_clock = 1'b0;
	logic i_arst_n = 1'b0;
	logic [11:0] i_avs_address = 12'h000;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [3:0] i_avs_byteenable = 4'hf;
	logic i_watchdog_timeout = 1'b0;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic o_power_down_flag;
	logic o_timeout_flag;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;

	always #20 i_clock = ~i_clock;

	mcuao_core mcuao_core_i (
		.i_clock(i_clock),
		.i_arst_n(i_arst_n),
		.i_avs_address(i_avs_address),
		.i_avs_read(i_avs_read),
		.i_avs_write(i_avs_write),
		.i_avs_writedata(i_avs_writedata),
		.i_avs_byteenable(i_avs_byteenable),
		.o_avs_readdata(o_avs_readdata),
		.o_avs_waitrequest(o_avs_waitrequest),
		.i_watchdog_timeout(i_watchdog_timeout),
		.o_power_down_flag(o_power_down_flag),
		.o_timeout_flag(o_timeout_flag)
	);

	task automatic chk(input string n, input logic [31:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task end_sim;
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	// Request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge i_clock);
		i_avs_address <= a;
		i_avs_writedata <= d;
		i_avs_write <= w;
		i_avs_read <= ~w;
		do @(posedge i_clock); while (o_avs_waitrequest !== 1'b0);
		q = o_avs_readdata;
		i_avs_write <= 1'b0;
		i_avs_read <= 1'b0;
	endtask : bus

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, {24'h0, d}, q);
	endtask : wr

	task automatic rd(input string n, input logic [11:0] a,
		input logic [7:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(n, q, {24'h0, e});
	endtask : rd

	function automatic logic [11:0] ra(input logic [6:0] n);
		return mcuao_pkg::OFS_RPAGE + {3'h0, n, 2'h0};
	endfunction : ra

	task automatic ex(input mcuao_pkg::mcuao_op_t op, input logic [6:0] r,
		input logic d, input logic [2:0] b, input logic [7:0] imm);
		logic [31:0] q;
		bus(1'b1, mcuao_pkg::OFS_INSTR, {8'h0, imm, 1'b0, b, d, r, op}, q);
		@(negedge i_clock);
	endtask : ex

	task automatic t_adds;
		wr(mcuao_pkg::OFS_ACCUM, 8'h12);
		wr(ra(7'h05), 8'h34);
		wr(mcuao_pkg::OFS_STATUS, 8'h04);
		ex(mcuao_pkg::OP_ADD_REG, 7'h05, 1'b1, 3'h0, 8'h00);
		rd("add_reg r", ra(7'h05), 8'h46);
		rd("add_reg accum", mcuao_pkg::OFS_ACCUM, 8'h12);
		rd("add_reg st", mcuao_pkg::OFS_STATUS, 8'h18);
		wr(mcuao_pkg::OFS_STATUS, 8'h04);
		ex(mcuao_pkg::OP_ADD_REG_WITH_CARRY, 7'h05, 1'b0, 3'h0, 8'h00);
		rd("adc_reg accum", mcuao_pkg::OFS_ACCUM, 8'h59);
		rd("adc_reg r", ra(7'h05), 8'h46);
		rd("adc_reg st", mcuao_pkg::OFS_STATUS, 8'h18);
		wr(mcuao_pkg::OFS_ACCUM, 8'hff);
		ex(mcuao_pkg::OP_ADD_IMM, 7'h00, 1'b0, 3'h0, 8'h01);
		rd("add_imm accum", mcuao_pkg::OFS_ACCUM, 8'h00);
		rd("add_imm st", mcuao_pkg::OFS_STATUS, 8'h1f);
		wr(mcuao_pkg::OFS_ACCUM, 8'h0f);
		ex(mcuao_pkg::OP_ADD_IMM_WITH_CARRY, 7'h00, 1'b0, 3'h0, 8'h00);
		rd("adc_imm accum", mcuao_pkg::OFS_ACCUM, 8'h10);
		rd("adc_imm st", mcuao_pkg::OFS_STATUS, 8'h1a);
		wr(mcuao_pkg::OFS_ACCUM, 8'h01);
		ex(mcuao_pkg::OP_ADD_IMM, 7'h00, 1'b0, 3'h0, 8'hff);
		rd("imm 255 accum", mcuao_pkg::OFS_ACCUM, 8'h00);
		// Carry is set here; a plain add must ignore it
		ex(mcuao_pkg::OP_ADD_REG, 7'h05, 1'b0, 3'h0, 8'h00);
		rd("add_reg d0", mcuao_pkg::OFS_ACCUM, 8'h46);
		rd("add_reg d0 st", mcuao_pkg::OFS_STATUS, 8'h18);
	endtask : t_adds

	task automatic t_and_clear;
		logic [7:0] e;
		wr(mcuao_pkg::OFS_ACCUM, 8'h5a);
		wr(ra(mcuao_pkg::RPAGE_LAST), 8'haf);
		wr(mcuao_pkg::OFS_STATUS, 8'h04);
		ex(mcuao_pkg::OP_AND_WITH_REG, 7'h7f, 1'b1, 3'h0, 8'h00);
		rd("and r", ra(7'h7f), 8'h0a);
		rd("and st", mcuao_pkg::OFS_STATUS, 8'h1c);
		wr(ra(7'h00), 8'ha5);
		ex(mcuao_pkg::OP_AND_WITH_REG, 7'h00, 1'b0, 3'h0, 8'h00);
		rd("and accum", mcuao_pkg::OFS_ACCUM, 8'h00);
		rd("and zero st", mcuao_pkg::OFS_STATUS, 8'h1d);
		wr(ra(7'h7f), 8'hff);
		for (int b = 0; b < 8; b++)
		begin
			e = 8'hff << (b + 1);
			ex(mcuao_pkg::OP_BIT_CLEAR, 7'h7f, 1'b0, 3'(b), 8'h00);
			rd("bit clear", ra(7'h7f), e);
		end
		rd("bit clear st", mcuao_pkg::OFS_STATUS, 8'h1d);
	endtask : t_and_clear

	task automatic wd_pulse;
		@(posedge i_clock);
		i_watchdog_timeout <= 1'b1;
		@(posedge i_clock);
		i_watchdog_timeout <= 1'b0;
		@(negedge i_clock);
		chk("to after timeout", {31'h0, o_timeout_flag}, 32'h0);
	endtask : wd_pulse

	task automatic t_flags;
		wd_pulse();
		ex(mcuao_pkg::OP_HALT_ENTRY, 7'h00, 1'b0, 3'h0, 8'h00);
		chk("pwrdn halt", {31'h0, o_power_down_flag}, 32'h0);
		chk("to halt", {31'h0, o_timeout_flag}, 32'h1);
		wd_pulse();
		ex(mcuao_pkg::OP_WATCHDOG_CLEAR, 7'h00, 1'b0, 3'h0, 8'h00);
		chk("pwrdn clear", {31'h0, o_power_down_flag}, 32'h1);
		chk("to clear", {31'h0, o_timeout_flag}, 32'h1);
		wr(mcuao_pkg::OFS_STATUS, 8'h00);
		rd("pwrdn to ro", mcuao_pkg::OFS_STATUS, 8'h18);
	endtask : t_flags

	task automatic t_map;
		wr(mcuao_pkg::OFS_SPAGE + 12'h07c, 8'h3c);
		rd("s page last", mcuao_pkg::OFS_SPAGE + 12'h07c, 8'h3c);
		wr(12'h600, 8'h77);
		rd("unmapped", 12'h600, 8'h00);
		rd("instr reads 0", mcuao_pkg::OFS_INSTR, 8'h00);
	endtask : t_map

	// Hang guard: counts as a mismatch
	always @(posedge i_clock)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			num_errors++;
			end_sim();
		end
	end

	initial
	begin
		repeat (3) @(posedge i_clock);
		i_arst_n <= 1'b1;
		@(negedge i_clock);
		chk("pwrdn reset", {31'h0, o_power_down_flag}, 32'h1);
		chk("to reset", {31'h0, o_timeout_flag}, 32'h1);
		rd("status reset", mcuao_pkg::OFS_STATUS, 8'h18);
		t_adds();
		t_and_clear();
		t_flags();
		t_map();
		end_sim();
	end
endmodule : mcu_arith_logic_ops_tb
